/* File: shared/adcsq_pkg.sv */
// Constants for the converter sequencing control block.
// Assumes an 8-bit special function register port from the CPU core.
package adcsq_pkg;

  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [7:0] ADDR_INT_ENABLE_ONE    = 8'hB8;
  localparam logic [7:0] ADDR_INT_REQUEST_ZERO  = 8'hC0;
  localparam logic [7:0] ADDR_CONV_CONTROL_ZERO = 8'hD8;
  localparam logic [7:0] ADDR_RESULT_LOW        = 8'hD9;
  localparam logic [7:0] ADDR_RESULT_HIGH       = 8'hDA;
  localparam logic [7:0] ADDR_CONV_CONTROL_ONE  = 8'hDC;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int IRQ_ENABLE_BIT  = 0;
  localparam int IRQ_REQUEST_BIT = 0;
  localparam int CONT_MODE_BIT   = 5;
  localparam int BUSY_BIT        = 4;
  localparam int PRESCALER_BIT   = 7;
  localparam int CHANNEL_MSB     = 3;
  localparam int RESULT_LOW_LSB  = 6;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] IRQ_RESET     = 8'h00;
  localparam logic [9:0] RESULT_RESET  = 10'h000;

  // ****************************************
  // Timing counts in system clocks, input clocks and machine cycles
  // ****************************************
  localparam int IN_CLK_DIV          = 2;
  localparam int PRESCALE_SLOW       = 4;
  localparam int PRESCALE_FAST_OFF   = 8;
  localparam int MACHINE_CYCLE_IN    = 12;
  localparam int MACHINE_CYCLE_CLKS  = MACHINE_CYCLE_IN * IN_CLK_DIV;
  localparam int CONV_CYCLES_DIV4    = 8;
  localparam int CONV_CYCLES_DIV8    = 16;
  localparam int SAMPLE_IN_DIV4      = 8;
  localparam int SAMPLE_IN_DIV8      = 16;

  typedef enum logic [1:0] {ADCSQ_IDLE, ADCSQ_SAMPLE, ADCSQ_CONVERT, ADCSQ_WRITE} adcsq_state_e;

endpackage

/* File: rtl/adcsq_control.sv */
// Sequencing control of a 10-bit successive-approximation converter.
// Assumes the CPU core drives a synchronous SFR port on clk, the system clock,
// and the analog core returns its conversion value by the end of the convert phase.
module adcsq_control #(
  parameter int CONV_CYCLES_DIV4 = adcsq_pkg::CONV_CYCLES_DIV4,
  parameter int CONV_CYCLES_DIV8 = adcsq_pkg::CONV_CYCLES_DIV8,
  parameter int SAMPLE_IN_DIV4   = adcsq_pkg::SAMPLE_IN_DIV4,
  parameter int SAMPLE_IN_DIV8   = adcsq_pkg::SAMPLE_IN_DIV8
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_we,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  input  wire logic [9:0] conv_value,
  output logic            in_clk,
  output logic            conv_clk,
  output logic            sample_connect,
  output logic            convert_active,
  output logic      [3:0] channel_sel,
  output logic            busy,
  output logic            adc_irq
);

  // ****************************************
  // Derived counts
  // ****************************************
  localparam int CNT_W      = 10;
  localparam int MC_LAST    = adcsq_pkg::MACHINE_CYCLE_CLKS - 1;
  localparam int END4       = CONV_CYCLES_DIV4 * adcsq_pkg::MACHINE_CYCLE_CLKS - 1;
  localparam int END8       = CONV_CYCLES_DIV8 * adcsq_pkg::MACHINE_CYCLE_CLKS - 1;
  localparam int SAMP4      = SAMPLE_IN_DIV4 * adcsq_pkg::IN_CLK_DIV - 1;
  localparam int SAMP8      = SAMPLE_IN_DIV8 * adcsq_pkg::IN_CLK_DIV - 1;
  localparam int HALF4      = adcsq_pkg::PRESCALE_SLOW / 2 - 1;
  localparam int HALF8      = adcsq_pkg::PRESCALE_FAST_OFF / 2 - 1;

  // ****************************************
  // Register state
  // ****************************************
  logic                    prescaler_select_reg;
  logic                    continuous_mode_bit_reg;
  logic [3:0]              channel_reg;
  logic                    converter_irq_enable_reg;
  logic                    converter_irq_request_reg;
  logic [9:0]              result_reg;
  logic                    done_once_reg;
  logic                    start_pending_reg;
  adcsq_pkg::adcsq_state_e state_reg;
  adcsq_pkg::adcsq_state_e state_next;
  logic [4:0]              mc_cnt_reg;
  logic [CNT_W-1:0]        conv_cnt_reg;
  logic [2:0]              div_cnt_reg;
  logic                    in_clk_reg;
  logic                    conv_clk_reg;
  logic                    sample_connect_reg;
  logic                    convert_active_reg;
  logic                    busy_reg;
  logic                    adc_irq_reg;
  logic [7:0]              sfr_rdata_reg;

  logic                    mc_end;
  logic                    write_result_low;
  logic                    write_control_zero;
  logic                    mode_rises;
  logic                    sample_end;
  logic                    conv_end;
  logic                    launch;

  assign mc_end             = (mc_cnt_reg == 5'(MC_LAST));
  assign write_result_low   = sfr_we && (sfr_addr == adcsq_pkg::ADDR_RESULT_LOW);
  assign write_control_zero = sfr_we && (sfr_addr == adcsq_pkg::ADDR_CONV_CONTROL_ZERO);
  assign mode_rises         = write_control_zero && sfr_wdata[adcsq_pkg::CONT_MODE_BIT]
                              && !continuous_mode_bit_reg;
  assign sample_end = (conv_cnt_reg == (prescaler_select_reg ? CNT_W'(SAMP8) : CNT_W'(SAMP4)));
  assign conv_end   = (conv_cnt_reg == (prescaler_select_reg ? CNT_W'(END8) : CNT_W'(END4)));
  // A pending start always wins; a finished write cycle continues in continuous mode
  assign launch = mc_end && (start_pending_reg ||
                  (state_reg == adcsq_pkg::ADCSQ_WRITE && continuous_mode_bit_reg));

  // ****************************************
  // Machine cycle and clock dividers
  // ****************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      mc_cnt_reg <= 5'h00;
    end else if (mc_end) begin
      mc_cnt_reg <= 5'h00;
    end else begin
      mc_cnt_reg <= mc_cnt_reg + 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      in_clk_reg <= 1'b0;
    end else begin
      in_clk_reg <= ~in_clk_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      div_cnt_reg  <= 3'h0;
      conv_clk_reg <= 1'b0;
    end else if (div_cnt_reg >= (prescaler_select_reg ? 3'(HALF8) : 3'(HALF4))) begin
      div_cnt_reg  <= 3'h0;
      conv_clk_reg <= ~conv_clk_reg;
    end else begin
      div_cnt_reg <= div_cnt_reg + 3'h1;
    end
  end

  // ****************************************
  // Software registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      prescaler_select_reg <= adcsq_pkg::CONTROL_RESET[adcsq_pkg::PRESCALER_BIT];
    end else if (sfr_we && sfr_addr == adcsq_pkg::ADDR_CONV_CONTROL_ONE) begin
      prescaler_select_reg <= sfr_wdata[adcsq_pkg::PRESCALER_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      channel_reg <= adcsq_pkg::CONTROL_RESET[adcsq_pkg::CHANNEL_MSB:0];
    end else if (write_control_zero ||
                 (sfr_we && sfr_addr == adcsq_pkg::ADDR_CONV_CONTROL_ONE)) begin
      channel_reg <= sfr_wdata[adcsq_pkg::CHANNEL_MSB:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      continuous_mode_bit_reg <= adcsq_pkg::CONTROL_RESET[adcsq_pkg::CONT_MODE_BIT];
    end else if (write_control_zero) begin
      continuous_mode_bit_reg <= sfr_wdata[adcsq_pkg::CONT_MODE_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      converter_irq_enable_reg <= adcsq_pkg::IRQ_RESET[adcsq_pkg::IRQ_ENABLE_BIT];
    end else if (sfr_we && sfr_addr == adcsq_pkg::ADDR_INT_ENABLE_ONE) begin
      converter_irq_enable_reg <= sfr_wdata[adcsq_pkg::IRQ_ENABLE_BIT];
    end
  end

  // Set by end of conversion wins over a software clear in the same cycle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      converter_irq_request_reg <= adcsq_pkg::IRQ_RESET[adcsq_pkg::IRQ_REQUEST_BIT];
    end else if (state_reg == adcsq_pkg::ADCSQ_CONVERT && conv_end) begin
      converter_irq_request_reg <= 1'b1;
    end else if (sfr_we && sfr_addr == adcsq_pkg::ADDR_INT_REQUEST_ZERO) begin
      converter_irq_request_reg <= sfr_wdata[adcsq_pkg::IRQ_REQUEST_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      adc_irq_reg <= 1'b0;
    end else begin
      adc_irq_reg <= converter_irq_request_reg && converter_irq_enable_reg;
    end
  end

  // ****************************************
  // Start requests
  // ****************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      start_pending_reg <= 1'b0;
    end else if (write_result_low) begin
      start_pending_reg <= 1'b1;
    end else if (mode_rises && done_once_reg && state_reg == adcsq_pkg::ADCSQ_IDLE) begin
      start_pending_reg <= 1'b1;
    end else if (launch) begin
      start_pending_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      done_once_reg <= 1'b0;
    end else if (state_reg == adcsq_pkg::ADCSQ_CONVERT && conv_end) begin
      done_once_reg <= 1'b1;
    end
  end

  // ****************************************
  // Conversion sequence
  // ****************************************
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      adcsq_pkg::ADCSQ_IDLE: begin
        if (launch) begin
          state_next = adcsq_pkg::ADCSQ_SAMPLE;
        end
      end
      adcsq_pkg::ADCSQ_SAMPLE: begin
        if (launch) begin
          state_next = adcsq_pkg::ADCSQ_SAMPLE;
        end else if (sample_end) begin
          state_next = adcsq_pkg::ADCSQ_CONVERT;
        end
      end
      adcsq_pkg::ADCSQ_CONVERT: begin
        if (launch) begin
          state_next = adcsq_pkg::ADCSQ_SAMPLE;
        end else if (conv_end) begin
          state_next = adcsq_pkg::ADCSQ_WRITE;
        end
      end
      adcsq_pkg::ADCSQ_WRITE: begin
        if (launch) begin
          state_next = adcsq_pkg::ADCSQ_SAMPLE;
        end else if (mc_end) begin
          state_next = adcsq_pkg::ADCSQ_IDLE;
        end
      end
      default: begin
        state_next = adcsq_pkg::ADCSQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_reg <= adcsq_pkg::ADCSQ_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      conv_cnt_reg <= '0;
    end else if (state_next == adcsq_pkg::ADCSQ_SAMPLE && (launch || state_reg == adcsq_pkg::ADCSQ_IDLE)) begin
      conv_cnt_reg <= '0;
    end else if (state_reg != adcsq_pkg::ADCSQ_IDLE) begin
      conv_cnt_reg <= conv_cnt_reg + CNT_W'(1);
    end
  end

  // Busy spans sample and convert, drops at the write cycle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      busy_reg           <= 1'b0;
      sample_connect_reg <= 1'b0;
      convert_active_reg <= 1'b0;
    end else begin
      busy_reg           <= (state_next == adcsq_pkg::ADCSQ_SAMPLE) ||
                            (state_next == adcsq_pkg::ADCSQ_CONVERT);
      sample_connect_reg <= (state_next == adcsq_pkg::ADCSQ_SAMPLE);
      convert_active_reg <= (state_next == adcsq_pkg::ADCSQ_CONVERT);
    end
  end

  // Result changes only on entry to the write cycle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      result_reg <= adcsq_pkg::RESULT_RESET;
    end else if (state_reg == adcsq_pkg::ADCSQ_CONVERT && state_next == adcsq_pkg::ADCSQ_WRITE) begin
      result_reg <= conv_value;
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sfr_rdata_reg <= 8'h00;
    end else begin
      case (sfr_addr)
        adcsq_pkg::ADDR_INT_ENABLE_ONE:
          sfr_rdata_reg <= 8'(converter_irq_enable_reg) << adcsq_pkg::IRQ_ENABLE_BIT;
        adcsq_pkg::ADDR_INT_REQUEST_ZERO:
          sfr_rdata_reg <= 8'(converter_irq_request_reg) << adcsq_pkg::IRQ_REQUEST_BIT;
        adcsq_pkg::ADDR_CONV_CONTROL_ZERO:
          sfr_rdata_reg <= (8'(continuous_mode_bit_reg) << adcsq_pkg::CONT_MODE_BIT) |
                           (8'(busy_reg) << adcsq_pkg::BUSY_BIT) | 8'(channel_reg);
        adcsq_pkg::ADDR_CONV_CONTROL_ONE:
          sfr_rdata_reg <= (8'(prescaler_select_reg) << adcsq_pkg::PRESCALER_BIT) | 8'(channel_reg);
        adcsq_pkg::ADDR_RESULT_LOW:
          sfr_rdata_reg <= 8'(result_reg[1:0]) << adcsq_pkg::RESULT_LOW_LSB;
        adcsq_pkg::ADDR_RESULT_HIGH:
          sfr_rdata_reg <= result_reg[9:2];
        default:
          sfr_rdata_reg <= 8'h00;
      endcase
    end
  end

  assign sfr_rdata      = sfr_rdata_reg;
  assign in_clk         = in_clk_reg;
  assign conv_clk       = conv_clk_reg;
  assign sample_connect = sample_connect_reg;
  assign convert_active = convert_active_reg;
  assign channel_sel    = channel_reg;
  assign busy           = busy_reg;
  assign adc_irq        = adc_irq_reg;

endmodule

/* File: sim/adcsq_cpu_model.sv */
// CPU core model that drives the special function register port.
// Assumes the bench calls wr and rd; every change lands on a falling edge.
module adcsq_cpu_model (
  input  wire logic       clk,
  output logic      [7:0] sfr_addr,
  output logic            sfr_we,
  output logic      [7:0] sfr_wdata,
  input  wire logic [7:0] sfr_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sfr_addr = 8'h00;
    sfr_we = 1'h0;
    sfr_wdata = 8'h00;
  end
  // Drives address, data and write enable for one clock, from one falling edge to the next
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_we = 1'h1;
    sfr_wdata = d;
    @(negedge clk);
    sfr_we = 1'h0;
    sfr_wdata = ~d;
  endtask
  // Read data is registered one edge behind the address
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    @(negedge clk);
    d = sfr_rdata;
  endtask
endmodule

/* File: sim/adcsq_control_asserts.sv */
// Checker for the converter sequencing control.
// Assumes it is bound onto adcsq_control and sees only its ports.
module adcsq_control_asserts #(
  parameter int CONV_CYCLES_DIV4 = 8,
  parameter int CONV_CYCLES_DIV8 = 16
) (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_we,
  input wire logic [7:0] sfr_wdata,
  input wire logic       in_clk,
  input wire logic       conv_clk,
  input wire logic       sample_connect,
  input wire logic       convert_active,
  input wire logic       busy,
  input wire logic       adc_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ****************************************
  // Shadow of written control bits
  // ****************************************
  logic       presc_reg;
  logic       en_reg;
  logic       cont_reg;
  logic [3:0] quiet_reg;
  wire        wr_dc  = sfr_we && sfr_addr == adcsq_pkg::ADDR_CONV_CONTROL_ONE;
  wire        wr_d8  = sfr_we && sfr_addr == adcsq_pkg::ADDR_CONV_CONTROL_ZERO;
  wire        wr_en  = sfr_we && sfr_addr == adcsq_pkg::ADDR_INT_ENABLE_ONE;
  wire        wr_irq = wr_en || (sfr_we && sfr_addr == adcsq_pkg::ADDR_INT_REQUEST_ZERO);
  always_ff @(posedge clk) begin
    if (!resetn) begin
      presc_reg <= 1'h0;
      en_reg <= 1'h0;
      cont_reg <= 1'h0;
    end else begin
      if (wr_dc) presc_reg <= sfr_wdata[adcsq_pkg::PRESCALER_BIT];
      if (wr_en) en_reg <= sfr_wdata[adcsq_pkg::IRQ_ENABLE_BIT];
      if (wr_d8) cont_reg <= sfr_wdata[adcsq_pkg::CONT_MODE_BIT];
    end
  end
  // Cycles since the divider was last written
  always_ff @(posedge clk) begin
    if (!resetn || wr_dc) quiet_reg <= 4'h0;
    else if (quiet_reg != 4'hF) quiet_reg <= quiet_reg + 4'h1;
  end
  // Start request written but not yet launched
  logic       trig_reg;
  wire        wr_d9  = sfr_we && sfr_addr == adcsq_pkg::ADDR_RESULT_LOW;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      trig_reg <= 1'h0;
    end else if (wr_d9 || (wr_d8 && sfr_wdata[adcsq_pkg::CONT_MODE_BIT])) begin
      trig_reg <= 1'h1;
    end else if ($rose(sample_connect)) begin
      trig_reg <= 1'h0;
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  sequence s_div4_period;
    conv_clk ##1 !conv_clk [*2] ##1 conv_clk;
  endsequence
  sequence s_div8_period;
    conv_clk [*3] ##1 !conv_clk [*4] ##1 conv_clk;
  endsequence
  sequence s_write_cycle;
    !busy [*8] ##16 !busy ##1 busy;
  endsequence
  a_in_clk_half: assert property (1'b1 |=> in_clk != $past(in_clk)) else $error("in_clk not half rate");
  a_div4_period: assert property (disable iff (!resetn || quiet_reg != 4'hF)
    $rose(conv_clk) && !presc_reg && quiet_reg == 4'hF |=> s_div4_period)
    else $error("conv_clk not clk over four");
  a_div8_period: assert property (disable iff (!resetn || quiet_reg != 4'hF)
    $rose(conv_clk) && presc_reg && quiet_reg == 4'hF |=> s_div8_period)
    else $error("conv_clk not clk over eight");
  a_start_busy: assert property (sfr_we && sfr_addr == adcsq_pkg::ADDR_RESULT_LOW |-> ##[1:26] busy)
    else $error("start write did not raise busy");
  a_busy_sample: assert property ($rose(busy) |-> sample_connect && !convert_active)
    else $error("busy rose outside sample phase");
  a_end_convert: assert property ($fell(busy) |-> $past(convert_active) && !sample_connect)
    else $error("conversion ended outside convert phase");
  a_irq_on_end: assert property ($fell(busy) && en_reg |=> adc_irq) else $error("no irq at end");
  a_irq_gated: assert property (!$past(en_reg) |-> !adc_irq) else $error("irq while disabled");
  a_irq_sticky: assert property (adc_irq && en_reg && !wr_irq && !$past(wr_irq) |=> adc_irq)
    else $error("request dropped without software");
  a_cont_restart: assert property ($fell(busy) && cont_reg |-> s_write_cycle)
    else $error("continuous restart mistimed");
  a_single_stop: assert property ($fell(busy) && !cont_reg |-> ##24 (!busy || trig_reg))
    else $error("conversion restarted without mode");
endmodule

bind adcsq_control adcsq_control_asserts #(
  .CONV_CYCLES_DIV4(CONV_CYCLES_DIV4),
  .CONV_CYCLES_DIV8(CONV_CYCLES_DIV8)
) u_adcsq_chk (
  .clk(clk), .resetn(resetn), .sfr_addr(sfr_addr), .sfr_we(sfr_we), .sfr_wdata(sfr_wdata),
  .in_clk(in_clk), .conv_clk(conv_clk), .sample_connect(sample_connect),
  .convert_active(convert_active), .busy(busy), .adc_irq(adc_irq)
);

/* File: sim/adc_sequencing_control_tb_top.sv */
// Self-checking bench for the converter sequencing control.
// Assumes adcsq_cpu_model drives the register port and the bench plays the analog core.
module adc_sequencing_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk;
  logic       resetn;
  logic [7:0] sfr_addr;
  logic       sfr_we;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic [9:0] conv_value;
  logic [3:0] channel_sel;
  logic       busy;
  logic       adc_irq;
  logic [7:0] rd_v;
  logic [3:0] ch;
  int         err_count;
  int         checked;
  int         vq[$];
  logic [7:0] addrs [7] = '{8'hB8, 8'hC0, 8'hD8, 8'hD9, 8'hDA, 8'hDC, 8'h00};
  adcsq_cpu_model i_cpu (.clk(clk), .sfr_addr(sfr_addr), .sfr_we(sfr_we), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata));
  adcsq_control i_dut (.clk(clk), .resetn(resetn), .sfr_addr(sfr_addr), .sfr_we(sfr_we),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .conv_value(conv_value), .in_clk(), .conv_clk(),
    .sample_connect(), .convert_active(), .channel_sel(channel_sel), .busy(busy), .adc_irq(adc_irq));
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  // New analog value for each conversion; the model keeps them in order
  always @(posedge busy) begin
    @(negedge clk);
    conv_value = 10'($urandom);
    vq.push_back(conv_value);
  end
  task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("Checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ****************************************
  // One conversion, its result and its request
  // ****************************************
  task automatic conv(input int len, input logic irq);
    int n;
    int v;
    n = 0;
    while (!busy && n < 30) begin
      @(negedge clk);
      n++;
    end
    check("start delay", 10'(n < 30), 10'h001);
    n = 0;
    while (busy && n < 1000) begin
      @(negedge clk);
      n++;
    end
    check("busy length", 10'(n), 10'(len));
    @(negedge clk);
    check("irq", adc_irq, irq);
    v = vq[$];
    i_cpu.rd(adcsq_pkg::ADDR_RESULT_HIGH, rd_v);
    check("result high", rd_v, v[9:2]);
    i_cpu.rd(adcsq_pkg::ADDR_RESULT_LOW, rd_v);
    check("result low", rd_v, {v[1:0], 6'h00});
    i_cpu.rd(adcsq_pkg::ADDR_INT_REQUEST_ZERO, rd_v);
    check("request flag", rd_v[0], 1'h1);
    i_cpu.wr(adcsq_pkg::ADDR_INT_REQUEST_ZERO, 8'h00);
    @(negedge clk);
    check("irq cleared", adc_irq, 1'h0);
  endtask
  // Mode bit cleared while this conversion runs
  task automatic conv_last(input int len);
    fork
      conv(len, 1'h1);
      begin
        repeat (60) @(negedge clk);
        i_cpu.wr(adcsq_pkg::ADDR_CONV_CONTROL_ZERO, {4'h0, ch});
      end
    join
    repeat (40) @(negedge clk);
    check("stopped", busy, 1'h0);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(12411));
    resetn = 1'h0;
    conv_value = 10'h000;
    repeat (2) @(negedge clk);
    resetn = 1'h1;
    foreach (addrs[i]) begin
      i_cpu.rd(addrs[i], rd_v);
      check("reset value", rd_v, 8'h00);
    end
    ch = 4'($urandom);
    i_cpu.wr(adcsq_pkg::ADDR_INT_ENABLE_ONE, 8'h01);
    i_cpu.wr(adcsq_pkg::ADDR_CONV_CONTROL_ZERO, {4'h2, ch});
    repeat (48) @(negedge clk);
    check("armed only", busy, 1'h0);
    check("channel", channel_sel, ch);
    i_cpu.wr(adcsq_pkg::ADDR_RESULT_LOW, 8'($urandom));
    conv(192, 1'h1);
    conv_last(192);
    i_cpu.wr(adcsq_pkg::ADDR_CONV_CONTROL_ZERO, {4'h2, ch});
    conv_last(192);
    i_cpu.wr(adcsq_pkg::ADDR_INT_ENABLE_ONE, 8'h00);
    i_cpu.wr(adcsq_pkg::ADDR_CONV_CONTROL_ONE, {4'h8, ch});
    i_cpu.wr(adcsq_pkg::ADDR_RESULT_LOW, 8'($urandom));
    conv(384, 1'h0);
    i_cpu.wr(adcsq_pkg::ADDR_CONV_CONTROL_ONE, {4'h0, ch});
    i_cpu.wr(adcsq_pkg::ADDR_INT_ENABLE_ONE, 8'h01);
    i_cpu.wr(adcsq_pkg::ADDR_RESULT_LOW, 8'($urandom));
    repeat (100) @(negedge clk);
    i_cpu.rd(adcsq_pkg::ADDR_CONV_CONTROL_ZERO, rd_v);
    check("busy bit", rd_v[adcsq_pkg::BUSY_BIT], 1'h1);
    i_cpu.wr(adcsq_pkg::ADDR_RESULT_LOW, 8'($urandom));
    repeat (150) @(negedge clk);
    check("restarted busy", busy, 1'h1);
    repeat (200) @(negedge clk);
    check("restart done", busy, 1'h0);
    i_cpu.wr(adcsq_pkg::ADDR_INT_REQUEST_ZERO, 8'h00);
    i_cpu.wr(adcsq_pkg::ADDR_RESULT_LOW, 8'($urandom));
    fork
      conv(192, 1'h1);
      begin
        repeat (60) @(negedge clk);
        i_cpu.wr(adcsq_pkg::ADDR_CONV_CONTROL_ZERO, {4'h2, ch});
      end
    join
    conv_last(192);
    conclude();
  end
  // Run needs under 2500 cycles; this limit is twenty times that
  initial begin
    #400us;
    err_count++;
    conclude();
  end
endmodule
